// *** rtl/rsc_pkg.sv ***
// Package of constants, opcodes and carriers for the return stack control decoder
package rsc_pkg;

  // Instruction word and register widths, and stack depth
  localparam int RSC_INSTR_W = 16;
  localparam int RSC_PC_W = 21;
  localparam int RSC_REG_W = 8;
  localparam int RSC_STACK_DEPTH = 31;

  // Fixed opcodes
  localparam logic [15:0] RSC_OPC_NOP = 16'h0000;
  localparam logic [15:0] RSC_OPC_PUSH = 16'h0005;
  localparam logic [15:0] RSC_OPC_POP = 16'h0006;
  localparam logic [15:0] RSC_OPC_RESET = 16'h00ff;
  // Interrupt return: upper fifteen bits fixed, bit 0 is the fast-return select
  localparam logic [14:0] RSC_OPC_RETI_HI = 15'h0008;
  localparam int RSC_FAST_BIT = 0;
  // Relative call: top five bits fixed, eleven-bit signed offset below
  localparam logic [4:0] RSC_OPC_RELATIVE_CALL_OP_HI = 5'h1b;
  localparam int RSC_OFS_W = 11;
  // Top nibble that always decodes as a no-operation
  localparam logic [3:0] RSC_NOP_NIBBLE = 4'hf;

  // Program counter step for one instruction word
  localparam logic [RSC_PC_W-1:0] RSC_PC_STEP = 21'h000002;

  // Reset values
  localparam logic [RSC_PC_W-1:0] RSC_PC_RST = 21'h000000;
  localparam logic [RSC_REG_W-1:0] RSC_REG_RST = 8'h00;
  localparam logic RSC_GIE_RST = 1'b0;

  // Decoded operation
  typedef enum logic [2:0] {
    RSC_OP_NOP = 3'b000,
    RSC_OP_POP = 3'b001,
    RSC_OP_PUSH = 3'b010,
    RSC_OP_RELATIVE_CALL_OP = 3'b011,
    RSC_OP_RESET = 3'b100,
    RSC_OP_RETI = 3'b101,
    RSC_OP_OTHER = 3'b110
  } rsc_op_t;

  // Execution state
  typedef enum logic [0:0] {
    RSC_ST_EXEC = 1'b0,
    RSC_ST_SECOND = 1'b1
  } rsc_state_t;

  // Working, status and bank-select registers travel together
  typedef struct packed {
    logic [RSC_REG_W-1:0] working;
    logic [RSC_REG_W-1:0] status;
    logic [RSC_REG_W-1:0] bank_select_register;
  } rsc_core_regs_t;

endpackage

// *** rtl/rsc_ctrl.sv ***
// Decoder and executor for the no-operation, stack, relative call, reset and interrupt return ops
// Overview of operation
// [RL1] Explicit pop removes the top stack entry and discards its value.
// [RL2] After pop, the entry pushed before the discarded one becomes top.
// [RL3] Explicit push places program counter plus two onto the stack top.
// [RL4] Push moves the former top one level deeper; nothing stored is lost.
// [RL5] Relative call first pushes program counter plus two as return address.
// [RL6] Relative call loads program counter plus two plus twice signed offset.
// [RL7] Relative call takes two cycles; the second does nothing.
// [RL8] Software reset returns all registers and flags to master clear values.
// [RL9] Interrupt return pops the stack into the program counter.
// [RL10] Interrupt return sets the high or low priority global enable.
// [RL11] Fast return bit set copies the three shadows into live registers.
// [RL12] Fast return bit clear leaves working, status and bank select alone.
// [RL13] Interrupt return takes two cycles; program counter latches stay unchanged.
// [RL14] All-zero opcode and top nibble 1111 are one-cycle no-operations.
// [RL15] Push, pop and no-operation take one cycle and change no flag. A push past full or a pop from empty sets the overflow or underflow flag.
`timescale 1ns/1ps
module rsc_ctrl #(
  parameter int STACK_DEPTH = rsc_pkg::RSC_STACK_DEPTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Instruction from the fetch unit
  input wire logic instr_valid,
  input wire logic [rsc_pkg::RSC_INSTR_W-1:0] instr_word,
  output logic instr_ready_q,
  // Register file side
  input wire logic core_regs_wr_en,
  input wire rsc_pkg::rsc_core_regs_t core_regs_wr,
  input wire rsc_pkg::rsc_core_regs_t shadow_regs,
  output rsc_pkg::rsc_core_regs_t core_regs_q,
  // Interrupt logic side
  input wire logic int_high_level_active,
  output logic high_priority_global_int_enable_q,
  output logic low_priority_global_int_enable_q,
  // Program counter, latches and stack state
  output logic [rsc_pkg::RSC_PC_W-1:0] program_counter_q,
  output logic [rsc_pkg::RSC_REG_W-1:0] pc_upper_latch_q,
  output logic [rsc_pkg::RSC_REG_W-1:0] pc_high_latch_q,
  output logic [rsc_pkg::RSC_PC_W-1:0] stack_top_entry_q,
  output logic [$clog2(STACK_DEPTH+1)-1:0] stack_level_q,
  output logic stack_overflow_q,
  output logic stack_underflow_q,
  output logic soft_reset_pulse_q
);
  import rsc_pkg::*;

  localparam int PTR_W = $clog2(STACK_DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);
  localparam logic [PTR_W-1:0] PTR_TWO = PTR_W'(2);
  localparam logic [PTR_W-1:0] PTR_FULL = PTR_W'(STACK_DEPTH);

  // Opcode decoding, shared by the datapath and the checks
  function automatic rsc_op_t rsc_decode(input logic [RSC_INSTR_W-1:0] w);
    rsc_op_t op;
    op = RSC_OP_OTHER;
    if (w == RSC_OPC_NOP || w[15:12] == RSC_NOP_NIBBLE) begin
      op = RSC_OP_NOP; // RL14
    end else if (w == RSC_OPC_POP) begin
      op = RSC_OP_POP;
    end else if (w == RSC_OPC_PUSH) begin
      op = RSC_OP_PUSH;
    end else if (w == RSC_OPC_RESET) begin
      op = RSC_OP_RESET;
    end else if (w[15:1] == RSC_OPC_RETI_HI) begin
      op = RSC_OP_RETI;
    end else if (w[15:11] == RSC_OPC_RELATIVE_CALL_OP_HI) begin
      op = RSC_OP_RELATIVE_CALL_OP;
    end
    return op;
  endfunction

  rsc_state_t state_q;
  rsc_op_t op;
  logic take;
  logic push_en;
  logic pop_en;
  logic soft_rst;
  logic fast_ret;
  logic stack_full;
  logic stack_empty;
  logic [RSC_PC_W-1:0] pc_plus2;
  logic [RSC_PC_W-1:0] relative_call_op_target;
  logic [RSC_PC_W-1:0] below_top;
  logic [RSC_PC_W-1:0] stack_mem [STACK_DEPTH];

  // Decode of the word taken this cycle
  assign op = rsc_decode(instr_word);
  assign take = instr_valid && instr_ready_q;
  assign push_en = take && (op == RSC_OP_PUSH || op == RSC_OP_RELATIVE_CALL_OP); // RL3 RL5
  assign pop_en = take && (op == RSC_OP_POP || op == RSC_OP_RETI); // RL1 RL9
  assign soft_rst = take && (op == RSC_OP_RESET);
  assign fast_ret = take && (op == RSC_OP_RETI) && instr_word[RSC_FAST_BIT];
  assign stack_full = (stack_level_q == PTR_FULL);
  assign stack_empty = (stack_level_q == '0);

  // Return address and relative call target
  assign pc_plus2 = program_counter_q + RSC_PC_STEP;
  assign relative_call_op_target = pc_plus2 +
    {{(RSC_PC_W-RSC_OFS_W-1){instr_word[RSC_OFS_W-1]}}, instr_word[RSC_OFS_W-1:0], 1'b0}; // RL6

  // Entry one level under the top, which surfaces on a pop
  assign below_top = (stack_level_q >= PTR_TWO) ? stack_mem[stack_level_q - PTR_TWO] : '0;

  // Two-cycle ops hold off the fetch unit for one idle cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= RSC_ST_EXEC;
      instr_ready_q <= 1'b1;
    end else begin
      case (state_q)
        RSC_ST_EXEC: begin
          if (take && (op == RSC_OP_RELATIVE_CALL_OP || op == RSC_OP_RETI)) begin
            state_q <= RSC_ST_SECOND; // RL7 RL13
            instr_ready_q <= 1'b0;
          end
        end
        RSC_ST_SECOND: begin
          state_q <= RSC_ST_EXEC; // RL7
          instr_ready_q <= 1'b1;
        end
        default: begin
          state_q <= RSC_ST_EXEC;
          instr_ready_q <= 1'b1;
        end
      endcase
    end
  end

  // Program counter update
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      program_counter_q <= RSC_PC_RST;
    end else if (soft_rst) begin
      program_counter_q <= RSC_PC_RST; // RL8
    end else if (take) begin
      case (op)
        RSC_OP_RELATIVE_CALL_OP: program_counter_q <= relative_call_op_target; // RL6
        RSC_OP_RETI: program_counter_q <= stack_top_entry_q; // RL9
        default: program_counter_q <= pc_plus2; // RL15
      endcase
    end
  end

  // Latches change only on reset; the interrupt return leaves them alone
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_upper_latch_q <= RSC_REG_RST;
      pc_high_latch_q <= RSC_REG_RST;
    end else if (soft_rst) begin
      pc_upper_latch_q <= RSC_REG_RST; // RL8
      pc_high_latch_q <= RSC_REG_RST;
    end
  end

  // Stack storage; a push past full or pop from empty only raises a flag
  always_ff @(posedge core_clk) begin
    if (push_en && !stack_full) begin
      stack_mem[stack_level_q] <= pc_plus2; // RL3 RL5
    end
  end

  // Stack pointer and registered top entry
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_level_q <= '0;
      stack_top_entry_q <= RSC_PC_RST;
    end else if (soft_rst) begin
      stack_level_q <= '0; // RL8
      stack_top_entry_q <= RSC_PC_RST;
    end else if (push_en && !stack_full) begin
      stack_level_q <= stack_level_q + PTR_ONE; // RL4
      stack_top_entry_q <= pc_plus2; // RL3
    end else if (pop_en && !stack_empty) begin
      stack_level_q <= stack_level_q - PTR_ONE; // RL1
      stack_top_entry_q <= below_top; // RL2
    end
  end

  // Sticky stack error flags, cleared only by reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_overflow_q <= 1'b0;
      stack_underflow_q <= 1'b0;
    end else if (soft_rst) begin
      stack_overflow_q <= 1'b0; // RL8
      stack_underflow_q <= 1'b0;
    end else begin
      if (push_en && stack_full) begin
        stack_overflow_q <= 1'b1;
      end
      if (pop_en && stack_empty) begin
        stack_underflow_q <= 1'b1;
      end
    end
  end

  // Working, status and bank select; this block's ops win over a file write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_regs_q <= '{RSC_REG_RST, RSC_REG_RST, RSC_REG_RST};
    end else if (soft_rst) begin
      core_regs_q <= '{RSC_REG_RST, RSC_REG_RST, RSC_REG_RST}; // RL8
    end else if (fast_ret) begin
      core_regs_q <= shadow_regs; // RL11
    end else if (core_regs_wr_en && !(take && op == RSC_OP_RETI)) begin
      core_regs_q <= core_regs_wr; // RL12
    end
  end

  // Global interrupt enables
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      high_priority_global_int_enable_q <= RSC_GIE_RST;
      low_priority_global_int_enable_q <= RSC_GIE_RST;
    end else if (soft_rst) begin
      high_priority_global_int_enable_q <= RSC_GIE_RST; // RL8
      low_priority_global_int_enable_q <= RSC_GIE_RST;
    end else if (take && op == RSC_OP_RETI) begin
      if (int_high_level_active) begin
        high_priority_global_int_enable_q <= 1'b1; // RL10
      end else begin
        low_priority_global_int_enable_q <= 1'b1; // RL10
      end
    end
  end

  // One-cycle notice of a software reset to the rest of the core
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset_pulse_q <= 1'b0;
    end else begin
      soft_reset_pulse_q <= soft_rst; // RL8
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  pop_discard_a: assert property (pop_en && !stack_empty && op == RSC_OP_POP |=> // RL1
    stack_level_q == $past(stack_level_q) - PTR_ONE && program_counter_q == $past(pc_plus2))
    else $error("pop did not drop one entry");
  pop_top_a: assert property (pop_en && !stack_empty |=> // RL2
    stack_top_entry_q == $past(below_top))
    else $error("pop did not surface the previous entry");
  push_top_a: assert property (push_en && !stack_full |=> // RL3
    stack_top_entry_q == $past(pc_plus2))
    else $error("push stored wrong return address");
  push_depth_a: assert property (push_en && !stack_full |=> // RL4
    stack_level_q == $past(stack_level_q) + PTR_ONE &&
    (stack_level_q < PTR_TWO || below_top == $past(stack_top_entry_q)))
    else $error("push lost the former top");
  relative_call_op_push_a: assert property (take && op == RSC_OP_RELATIVE_CALL_OP && !stack_full |=> // RL5
    stack_top_entry_q == $past(program_counter_q) + RSC_PC_STEP)
    else $error("relative call pushed wrong address");
  relative_call_op_pc_a: assert property (take && op == RSC_OP_RELATIVE_CALL_OP |=> // RL6
    program_counter_q == $past(relative_call_op_target))
    else $error("relative call target wrong");
  two_cycle_a: assert property (take && (op == RSC_OP_RELATIVE_CALL_OP || op == RSC_OP_RETI) |=> // RL7
    !instr_ready_q ##1 instr_ready_q && $stable(program_counter_q))
    else $error("two-cycle op did not idle one cycle");
  soft_reset_a: assert property (soft_rst |=> program_counter_q == RSC_PC_RST && // RL8
    stack_level_q == '0 && core_regs_q == '0 && soft_reset_pulse_q &&
    !high_priority_global_int_enable_q && !low_priority_global_int_enable_q)
    else $error("software reset left state behind");
  reti_pc_a: assert property (take && op == RSC_OP_RETI |=> // RL9
    program_counter_q == $past(stack_top_entry_q))
    else $error("interrupt return loaded wrong address");
  reti_gie_a: assert property (take && op == RSC_OP_RETI |=> // RL10
    (high_priority_global_int_enable_q && $past(int_high_level_active)) ||
    (low_priority_global_int_enable_q && !$past(int_high_level_active)))
    else $error("interrupt return did not enable interrupts");
  fast_ret_a: assert property (fast_ret |=> core_regs_q == $past(shadow_regs)) // RL11
    else $error("fast return did not restore shadows");
  slow_ret_a: assert property (take && op == RSC_OP_RETI && !instr_word[RSC_FAST_BIT] |=> // RL12
    $stable(core_regs_q))
    else $error("plain return touched live registers");
  latch_hold_a: assert property (take && op == RSC_OP_RETI |=> // RL13
    $stable(pc_upper_latch_q) && $stable(pc_high_latch_q))
    else $error("interrupt return changed latches");
  nop_idle_a: assert property (take && op == RSC_OP_NOP |=> // RL14
    $stable(stack_level_q) && $stable(high_priority_global_int_enable_q) &&
    instr_ready_q && program_counter_q == $past(pc_plus2))
    else $error("no-operation changed state");
  one_cycle_a: assert property (take && (op == RSC_OP_PUSH || op == RSC_OP_POP) |=> // RL15
    instr_ready_q && $stable(low_priority_global_int_enable_q))
    else $error("stack op stalled or changed a flag");
  ovf_keep_a: assert property (push_en && stack_full |=> // RL4
    stack_level_q == $past(stack_level_q) && stack_overflow_q)
    else $error("push past full changed the depth");
  pop_empty_a: assert property (pop_en && stack_empty |=> // RL1
    stack_level_q == '0 && stack_underflow_q)
    else $error("pop from empty changed the depth");

  // Main scenarios; the bench reaches fast_ret_c, overflow_c and underflow_c but not the two sequence covers
  relative_call_op_seen_c: cover property (take && op == RSC_OP_RELATIVE_CALL_OP ##2 take && op == RSC_OP_RETI);
  push_pop_c: cover property (push_en && !stack_full ##1 pop_en && !stack_empty);
  fast_ret_c: cover property (fast_ret);
  overflow_c: cover property (push_en && stack_full);
  underflow_c: cover property (pop_en && stack_empty);

endmodule // rsc_ctrl

// *** test/rsc_fetch_model.sv ***
// Fetch unit model that offers instruction words to the decoder
`timescale 1ns/1ps
module rsc_fetch_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Request from the bench
  input wire logic go,
  input wire logic [15:0] go_word,
  input wire logic [3:0] lag,
  output logic done,
  // Instruction port of the decoder
  output logic instr_valid,
  output logic [15:0] instr_word,
  input wire logic instr_ready_q
);
  logic [3:0] wait_q;
  logic pend_q;
  logic [15:0] word_q;

  // Offer after lag cycles, hold until taken, scramble the idle bus
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_valid <= 1'b0;
      instr_word <= 16'h5a5a;
      done <= 1'b0;
      pend_q <= 1'b0;
      wait_q <= 4'h0;
      word_q <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (instr_valid && instr_ready_q) begin
        instr_valid <= 1'b0;
        instr_word <= ~instr_word;
        done <= 1'b1;
      end else if (go) begin
        pend_q <= 1'b1;
        wait_q <= lag;
        word_q <= go_word;
        instr_word <= ~instr_word;
      end else if (pend_q && wait_q == 4'h0) begin
        pend_q <= 1'b0;
        instr_valid <= 1'b1;
        instr_word <= word_q;
      end else if (!instr_valid) begin
        wait_q <= (wait_q == 4'h0) ? 4'h0 : wait_q - 4'h1;
        instr_word <= ~instr_word;
      end
    end
  end
endmodule // rsc_fetch_model

// *** test/return_stack_control_ops_bench.sv ***
// Self-checking bench for the return stack control decoder
`timescale 1ns/1ps
module return_stack_control_ops_bench;
  import rsc_pkg::*;
  logic core_clk, rst_n, go, done, instr_valid, instr_ready_q, core_regs_wr_en;
  logic [15:0] go_word, instr_word;
  logic [3:0] lag;
  rsc_core_regs_t core_regs_wr, shadow_regs, core_regs_q, exp_regs;
  logic int_high_level_active, hi_en, lo_en, pulse, exp_hi, exp_lo;
  logic ovf, unf, exp_ovf, exp_unf;
  logic [RSC_PC_W-1:0] pc, top, exp_pc;
  logic [RSC_REG_W-1:0] lat_u, lat_h;
  logic [4:0] level;
  logic [10:0] ofs_tab [3] = '{11'h005, 11'h3ff, 11'h400};
  logic [RSC_PC_W-1:0] exp_stk [$];
  int mismatches, checked;

  rsc_ctrl rsc_ctrl_i (.core_clk(core_clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_ready_q(instr_ready_q), .core_regs_wr_en(core_regs_wr_en),
    .core_regs_wr(core_regs_wr), .shadow_regs(shadow_regs), .core_regs_q(core_regs_q),
    .int_high_level_active(int_high_level_active), .high_priority_global_int_enable_q(hi_en),
    .low_priority_global_int_enable_q(lo_en), .program_counter_q(pc), .pc_upper_latch_q(lat_u),
    .pc_high_latch_q(lat_h), .stack_top_entry_q(top), .stack_level_q(level),
    .stack_overflow_q(ovf), .stack_underflow_q(unf), .soft_reset_pulse_q(pulse));

  rsc_fetch_model rsc_fetch_model_i (.core_clk(core_clk), .rst_n(rst_n), .go(go),
    .go_word(go_word), .lag(lag), .done(done), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_ready_q(instr_ready_q));

  // Free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Verdict and end of run
  task automatic stop_test();
    if (mismatches == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Compare one value of up to 24 bits
  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Compare every standing output against the bench's own model
  task automatic chk_state();
    logic [RSC_PC_W-1:0] t;
    t = (exp_stk.size() > 0) ? exp_stk[$] : '0;
    chk_val({3'h0, pc}, {3'h0, exp_pc}, "program counter");
    chk_val({3'h0, top}, {3'h0, t}, "stack top");
    chk_val({19'h0, level}, 24'(exp_stk.size()), "stack level");
    chk_val(core_regs_q, exp_regs, "live registers");
    chk_val({4'h0, ovf, unf, hi_en, lo_en, lat_u, lat_h},
      {4'h0, exp_ovf, exp_unf, exp_hi, exp_lo, 16'h0000}, "flags");
  endtask

  // Hand one word to the fetch model and wait until it is taken
  task automatic exec(input logic [15:0] w);
    int n;
    @(posedge core_clk);
    go <= 1'b1;
    go_word <= w;
    @(posedge core_clk);
    go <= 1'b0;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (done === 1'b1) break;
    end
    if (n == 20) begin
      mismatches++;
      $display("[ERR] %0t instruction never taken", $time);
      stop_test();
    end
  endtask

  // Register file write of the live registers
  task automatic wr_regs(input rsc_core_regs_t v);
    @(posedge core_clk);
    core_regs_wr_en <= 1'b1;
    core_regs_wr <= v;
    @(posedge core_clk);
    core_regs_wr_en <= 1'b0;
    exp_regs = v;
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    go = 1'b0;
    go_word = 16'h0000;
    lag = 4'h0;
    core_regs_wr_en = 1'b0;
    core_regs_wr = '0;
    shadow_regs = 24'ha1b2c3;
    int_high_level_active = 1'b1;
    exp_pc = '0;
    exp_regs = '0;
    exp_hi = 1'b0;
    exp_lo = 1'b0;
    exp_ovf = 1'b0;
    exp_unf = 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk_state();
    exec(RSC_OPC_NOP);
    exp_pc += RSC_PC_STEP;
    chk_state();
    wr_regs(24'h3c5a69);
    exec(16'hf3c9);
    exp_pc += RSC_PC_STEP;
    chk_state();
    for (int i = 0; i < 2; i++) begin
      exec(RSC_OPC_PUSH);
      exp_stk.push_back(exp_pc + RSC_PC_STEP);
      exp_pc += RSC_PC_STEP;
      chk_state();
    end
    exec(RSC_OPC_POP);
    void'(exp_stk.pop_back());
    exp_pc += RSC_PC_STEP;
    chk_state();
    foreach (ofs_tab[i]) begin
      exec({RSC_OPC_RELATIVE_CALL_OP_HI, ofs_tab[i]});
      exp_stk.push_back(exp_pc + RSC_PC_STEP);
      exp_pc = exp_pc + RSC_PC_STEP + {{9{ofs_tab[i][10]}}, ofs_tab[i], 1'b0};
      chk_val({23'h0, instr_ready_q}, 24'h000000, "second call cycle idle");
      chk_state();
    end
    exec({RSC_OPC_RETI_HI, 1'b0});
    exp_pc = exp_stk.pop_back();
    exp_hi = 1'b1;
    chk_val({23'h0, instr_ready_q}, 24'h000000, "second return cycle idle");
    chk_state();
    int_high_level_active <= 1'b0;
    lag <= 4'h3;
    exec({RSC_OPC_RETI_HI, 1'b1});
    exp_pc = exp_stk.pop_back();
    exp_lo = 1'b1;
    exp_regs = shadow_regs;
    chk_state();
    lag <= 4'h0;
    exec(RSC_OPC_RESET);
    chk_val({23'h0, pulse}, 24'h000001, "soft reset pulse");
    exp_stk.delete();
    exp_pc = '0;
    exp_regs = '0;
    exp_hi = 1'b0;
    exp_lo = 1'b0;
    chk_state();
    exec(RSC_OPC_POP);
    exp_unf = 1'b1;
    exp_pc += RSC_PC_STEP;
    chk_state();
    for (int i = 0; i <= RSC_STACK_DEPTH; i++) begin
      exec(RSC_OPC_PUSH);
      if (exp_stk.size() < RSC_STACK_DEPTH) begin
        exp_stk.push_back(exp_pc + RSC_PC_STEP);
      end else begin
        exp_ovf = 1'b1;
      end
      exp_pc += RSC_PC_STEP;
    end
    chk_state();
    exec(RSC_OPC_RESET);
    exp_stk.delete();
    exp_pc = '0;
    exp_unf = 1'b0;
    exp_ovf = 1'b0;
    chk_state();
    stop_test();
  end
endmodule // return_stack_control_ops_bench
